// ===== pkg/exec_unit_regs.vh
// Opcodes, field positions and cycle counts of the branch and load unit.
// Holds definitions only; included by bare name from the branch and load unit's design file.
`ifndef EXEC_UNIT_REGS_VH
`define EXEC_UNIT_REGS_VH

// Low-nibble opcodes; the high nibble is a register or condition field
`define NIB_BRANCH      4'hb
`define NIB_LD_IMM      4'hc
`define NIB_LD_RSRC     4'h8
`define NIB_LD_RDST     4'h9

// Full-byte opcodes of the general load and the bit load
`define OP_LD_IND_SRC   8'hc7
`define OP_LD_IND_DST   8'hd7
`define OP_LD_RR        8'he4
`define OP_LD_R_IR      8'he5
`define OP_LD_R_IM      8'he6
`define OP_LD_IR_IM     8'hd6
`define OP_LD_IR_R      8'hf5
`define OP_LD_X_SRC     8'h87
`define OP_LD_X_DST     8'h97
`define OP_BLD          8'h47

// Memory load opcodes
`define OP_MLD_IND      8'hc3
`define OP_MST_IND      8'hd3
`define OP_MLD_XS       8'he7
`define OP_MST_XS       8'hf7
`define OP_MLD_XL       8'ha7
`define OP_MST_XL       8'hb7
`define OP_MLD_DEC      8'he2

// Second-byte fields of the bit load
`define BLD_DIR_BIT     0
`define BLD_IDX_HI      3
`define BLD_IDX_LO      1

// Pair field upper bits that mean direct addressing in the long forms
`define PAIR_DIRECT     3'h0

// Pair decrement addend (minus one, modulo 16 bits)
`define PAIR_MINUS_ONE  16'hffff

// Instruction lengths in clock cycles
`define CYC_SHORT       4'h4
`define CYC_LONG        4'h6
`define CYC_BRANCH      4'h6
`define CYC_MEM_IND     4'ha
`define CYC_MEM_XS      4'hc
`define CYC_MEM_XL      4'he
`define CYC_MEM_DEC     4'ha

// Reset value of the program counter
`define PC_RESET        16'h0000

`endif

// ===== verilog/bit_splice.v
// Replaces one bit of a byte, leaving the other seven untouched.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ns
module bit_splice (
	input  wire [7:0] base_in,
	input  wire       bit_in,
	input  wire [2:0] idx_in,
	output wire [7:0] merged_out
);
	wire [7:0] sel_mask;

	assign sel_mask   = 8'h01 << idx_in;
	assign merged_out = (base_in & ~sel_mask) | ({8{bit_in}} & sel_mask);
endmodule

// ===== verilog/offset_adder16.v
// Sixteen-bit address adder that wraps modulo the address space.
// Pure combinational; operands are already extended by the caller.
`timescale 1ns/1ns
module offset_adder16 (
	input  wire [15:0] base_in,
	input  wire [15:0] offset_in,
	output wire [15:0] sum_out
);
	assign sum_out = base_in + offset_in;
endmodule

// ===== verilog/branch_and_load_exec_unit.v
// Decode and execute for relative branch, general, bit and memory loads.
// Assumes a byte fetch stream, a register file read combinationally
// at reg_addr_out, and memories returning data the cycle after a read.
//
// Notes on behaviour
// [RQ1] Taken branch adds displacement; six cycles
// [RQ2] Displacement is signed, -128 to +127
// [RQ3] Branch base is address after branch
// [RQ4] Branch is two bytes, condition high nibble
// [RQ5] General load copies source, source unchanged
// [RQ6] Short loads: register in opcode high nibble
// [RQ7] Bit load moves one bit either way
// [RQ8] Other destination bits and source kept
// [RQ9] Second byte: register, bit index, direction
// [RQ10] Memory load moves byte; indirect ten cycles
// [RQ11] Pair LSB: even program, odd data
// [RQ12] Short index: three bytes, twelve cycles
// [RQ13] Long index: four bytes, low offset first
// [RQ14] Long forms: pair 0000/0001 mean direct
// [RQ15] Direct: 0000 program, 0001 data memory
// [RQ16] No program stores on masked ROM
// [RQ17] Post-decrement load: read, pair minus one
// [RQ18] Flag register never modified
// [RQ19] Displacement sign-extended, sum wraps 16 bits
// [RQ20] Pair decrement borrows into high byte
`timescale 1ns/1ns
`include "exec_unit_regs.vh"
module branch_and_load_exec_unit (
	input  wire        clk_in,
	input  wire        rstn_in,
	input  wire [7:0]  fetch_byte_in,
	input  wire        fetch_valid_in,
	output wire        fetch_take_out,
	output wire [15:0] pc_out,
	output wire        pc_load_out,
	output wire [3:0]  cond_code_out,
	input  wire        cond_true_in,
	input  wire [7:0]  wreg_base_in,
	output wire [7:0]  reg_addr_out,
	input  wire [7:0]  reg_rdata_in,
	output wire        reg_we_out,
	output wire [7:0]  reg_wdata_out,
	output wire [15:0] mem_addr_out,
	output wire        mem_data_space_out,
	output wire        mem_rd_out,
	output wire        mem_wr_out,
	output wire [7:0]  mem_wdata_out,
	input  wire [7:0]  mem_rdata_in,
	input  wire        rom_masked_in,
	output wire        done_out,
	output wire        illegal_out
);
	localparam ST_OP   = 7'h01;
	localparam ST_OPND = 7'h02;
	localparam ST_RD   = 7'h04;
	localparam ST_MEM  = 7'h08;
	localparam ST_MDAT = 7'h10;
	localparam ST_WR   = 7'h20;
	localparam ST_PAD  = 7'h40;

	reg  [6:0]  state_ff;
	reg  [7:0]  op_ff;
	reg  [7:0]  b1_ff;
	reg  [7:0]  b2_ff;
	reg  [7:0]  b3_ff;
	reg  [1:0]  bcnt_ff;
	reg  [3:0]  cyc_ff;
	reg  [1:0]  rd_idx_ff;
	reg  [1:0]  wr_idx_ff;
	reg  [7:0]  v0_ff;
	reg  [7:0]  v1_ff;
	reg  [7:0]  v2_ff;
	reg  [7:0]  mdat_ff;
	reg         jr_pend_ff;
	reg         rom_s1_ff;
	reg         rom_s2_ff;
	reg         take_ff;
	reg  [15:0] pc_ff;
	reg         pc_load_ff;
	reg  [3:0]  cnd_ff;
	reg  [7:0]  reg_addr_ff;
	reg         reg_we_ff;
	reg  [7:0]  reg_wdata_ff;
	reg  [15:0] mem_addr_ff;
	reg         mem_space_ff;
	reg         mem_rd_ff;
	reg         mem_wr_ff;
	reg  [7:0]  mem_wdata_ff;
	reg         done_ff;
	reg         illegal_ff;

	wire        taken;
	wire [7:0]  dop;
	wire [7:0]  bb1;
	wire [7:0]  bb2;
	wire [7:0]  bb3;
	wire [7:0]  vv0;
	wire [7:0]  vv1;
	wire [7:0]  vv2;
	wire [7:0]  md;
	wire [1:0]  rsel;
	wire [1:0]  wsel;
	wire        op_last;
	wire        is_dec;
	wire        is_long;
	wire        is_direct;
	wire [15:0] pair;
	wire [15:0] disp_ext;
	wire [15:0] mem_off;
	wire [15:0] add_sum;
	wire [15:0] dec_sum;
	wire [7:0]  splice_base;
	wire        splice_bit;
	wire [2:0]  splice_idx;
	wire [7:0]  spliced;
	wire        store_blocked;

	reg  [2:0]  d_nb;
	reg  [3:0]  d_cyc;
	reg  [1:0]  d_rdn;
	reg  [1:0]  d_wrn;
	reg         d_mem;
	reg         d_ld;
	reg         d_jr;
	reg  [7:0]  rd_addr;
	reg  [7:0]  wr_addr;
	reg  [7:0]  wr_data;

	function [7:0] wreg;
		input [3:0] num;
		wreg = {wreg_base_in[7:4], num};
	endfunction

	////////////////////////////////////////////////////////////////////
	// Live operand views: bytes and reads arriving in this very cycle
	assign taken   = take_ff & fetch_valid_in;
	assign dop     = (state_ff == ST_OP) ? fetch_byte_in : op_ff;
	assign op_last = ({1'b0, bcnt_ff} + 3'h2) == d_nb;
	assign bb1 = (state_ff == ST_OPND && bcnt_ff == 2'h0) ?
		fetch_byte_in : b1_ff;
	assign bb2 = (state_ff == ST_OPND && bcnt_ff == 2'h1) ?
		fetch_byte_in : b2_ff;
	assign bb3 = (state_ff == ST_OPND && bcnt_ff == 2'h2) ?
		fetch_byte_in : b3_ff;
	assign vv0 = (state_ff == ST_RD && rd_idx_ff == 2'h0) ?
		reg_rdata_in : v0_ff;
	assign vv1 = (state_ff == ST_RD && rd_idx_ff == 2'h1) ?
		reg_rdata_in : v1_ff;
	assign vv2 = (state_ff == ST_RD && rd_idx_ff == 2'h2) ?
		reg_rdata_in : v2_ff;
	assign md   = (state_ff == ST_MDAT) ? mem_rdata_in : mdat_ff;
	assign rsel = (state_ff == ST_RD) ? rd_idx_ff + 2'h1 : 2'h0;
	assign wsel = (state_ff == ST_WR) ? wr_idx_ff + 2'h1 : 2'h0;

	////////////////////////////////////////////////////////////////////
	// Address arithmetic
	assign is_dec    = op_ff == `OP_MLD_DEC;
	assign is_long   = op_ff == `OP_MLD_XL || op_ff == `OP_MST_XL;
	assign is_direct = is_long && b1_ff[3:1] == `PAIR_DIRECT; // RQ14
	assign pair      = {v0_ff, v1_ff};
	assign disp_ext  = {{8{b1_ff[7]}}, b1_ff}; // RQ2 RQ19
	assign mem_off   = is_long ? {b3_ff, b2_ff} : // RQ13
		(op_ff == `OP_MLD_XS || op_ff == `OP_MST_XS) ?
		{8'h00, b2_ff} : 16'h0000; // RQ12

	offset_adder16 u_addr_add (
		.base_in   (jr_pend_ff ? pc_ff : pair),
		.offset_in (jr_pend_ff ? disp_ext : mem_off),
		.sum_out   (add_sum)
	);

	offset_adder16 u_pair_dec (
		.base_in   (pair),
		.offset_in (`PAIR_MINUS_ONE),
		.sum_out   (dec_sum)
	);

	// Bit load: direction 0 fills bit 0, direction 1 fills bit b
	assign splice_base = bb1[`BLD_DIR_BIT] ? vv1 : vv0; // RQ8
	assign splice_bit  = bb1[`BLD_DIR_BIT] ? vv0[0] :
		vv1[bb1[`BLD_IDX_HI:`BLD_IDX_LO]]; // RQ7
	assign splice_idx  = bb1[`BLD_DIR_BIT] ?
		bb1[`BLD_IDX_HI:`BLD_IDX_LO] : 3'h0; // RQ9

	bit_splice u_splice (
		.base_in    (splice_base),
		.bit_in     (splice_bit),
		.idx_in     (splice_idx),
		.merged_out (spliced)
	);

	assign store_blocked = rom_s2_ff & ~b1_ff[0]; // RQ16

	////////////////////////////////////////////////////////////////////
	// Opcode decode: length, cycles, register reads and writes
	always @* begin
		d_nb  = 3'h1;
		d_cyc = `CYC_SHORT;
		d_rdn = 2'h0;
		d_wrn = 2'h1;
		d_mem = 1'b0;
		d_ld  = 1'b0;
		d_jr  = 1'b0;
		case (dop[3:0])
		`NIB_BRANCH: begin
			d_nb  = 3'h2; // RQ4
			d_cyc = `CYC_BRANCH; // RQ1
			d_wrn = 2'h0;
			d_jr  = 1'b1;
		end
		`NIB_LD_IMM: d_nb = 3'h2; // RQ6
		`NIB_LD_RSRC, `NIB_LD_RDST: begin
			d_nb  = 3'h2; // RQ6
			d_rdn = 2'h1;
		end
		default: begin
			case (dop)
			`OP_LD_IND_SRC, `OP_LD_IND_DST: begin
				d_nb  = 3'h2;
				d_rdn = 2'h2;
			end
			`OP_LD_RR, `OP_LD_IR_IM: begin
				d_nb  = 3'h3;
				d_cyc = `CYC_LONG;
				d_rdn = 2'h1;
			end
			`OP_LD_R_IR, `OP_LD_IR_R, `OP_LD_X_SRC, `OP_LD_X_DST,
			`OP_BLD: begin
				d_nb  = 3'h3; // RQ5
				d_cyc = `CYC_LONG;
				d_rdn = 2'h2;
			end
			`OP_LD_R_IM: begin
				d_nb  = 3'h3;
				d_cyc = `CYC_LONG;
			end
			`OP_MLD_IND, `OP_MST_IND, `OP_MLD_DEC: begin
				d_nb  = 3'h2;
				d_cyc = `CYC_MEM_IND; // RQ10 RQ17
				d_rdn = 2'h3;
				d_mem = 1'b1;
			end
			`OP_MLD_XS, `OP_MST_XS: begin
				d_nb  = 3'h3;
				d_cyc = `CYC_MEM_XS; // RQ12
				d_rdn = 2'h3;
				d_mem = 1'b1;
			end
			`OP_MLD_XL, `OP_MST_XL: begin
				d_nb  = 3'h4;
				d_cyc = `CYC_MEM_XL; // RQ13
				d_rdn = 2'h3;
				d_mem = 1'b1;
			end
			default: d_wrn = 2'h0;
			endcase
			d_ld = dop == `OP_MLD_IND || dop == `OP_MLD_XS ||
				dop == `OP_MLD_XL || dop == `OP_MLD_DEC;
			if (d_mem) begin
				d_wrn = d_ld ? ((dop == `OP_MLD_DEC) ? 2'h3 : 2'h1) :
					2'h0;
			end
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Register read address for slot rsel
	always @* begin
		rd_addr = 8'h00;
		case (op_ff)
		`OP_LD_IND_SRC: rd_addr = (rsel == 2'h0) ? wreg(bb1[3:0]) : vv0;
		`OP_LD_IND_DST: rd_addr = (rsel == 2'h0) ?
			wreg(bb1[7:4]) : wreg(bb1[3:0]);
		`OP_LD_RR, `OP_LD_R_IR: rd_addr = (rsel == 2'h0) ? bb1 : vv0;
		`OP_LD_IR_IM: rd_addr = bb1;
		`OP_LD_IR_R: rd_addr = (rsel == 2'h0) ? bb1 : bb2;
		`OP_LD_X_SRC: rd_addr = (rsel == 2'h0) ?
			wreg(bb1[3:0]) : bb2 + vv0;
		`OP_LD_X_DST: rd_addr = (rsel == 2'h0) ?
			wreg(bb1[3:0]) : wreg(bb1[7:4]);
		`OP_BLD: rd_addr = (rsel == 2'h0) ? wreg(bb1[7:4]) : bb2;
		`OP_MLD_IND, `OP_MST_IND, `OP_MLD_XS, `OP_MST_XS, `OP_MLD_XL,
		`OP_MST_XL, `OP_MLD_DEC: begin
			rd_addr = (rsel == 2'h0) ? wreg({bb1[3:1], 1'b0}) :
				(rsel == 2'h1) ? wreg({bb1[3:1], 1'b1}) :
				wreg(bb1[7:4]);
		end
		default: begin
			if (op_ff[3:0] == `NIB_LD_RSRC)
				rd_addr = bb1;
			else
				rd_addr = wreg(op_ff[7:4]);
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Register write address and data for slot wsel; only the register
	// port, the memory port and the PC are ever written, never the flags
	always @* begin
		wr_addr = bb1; // RQ18
		wr_data = vv0;
		case (op_ff)
		`OP_LD_IND_SRC, `OP_LD_X_SRC: begin
			wr_addr = wreg(bb1[7:4]);
			wr_data = vv1;
		end
		`OP_LD_IND_DST: begin
			wr_addr = vv0;
			wr_data = vv1;
		end
		`OP_LD_RR: wr_addr = bb2;
		`OP_LD_R_IR: begin
			wr_addr = bb2;
			wr_data = vv1;
		end
		`OP_LD_R_IM: wr_data = bb2;
		`OP_LD_IR_IM: begin
			wr_addr = vv0;
			wr_data = bb2;
		end
		`OP_LD_IR_R: wr_addr = vv1;
		`OP_LD_X_DST: begin
			wr_addr = bb2 + vv0;
			wr_data = vv1;
		end
		`OP_BLD: begin
			wr_addr = bb1[`BLD_DIR_BIT] ? bb2 : wreg(bb1[7:4]);
			wr_data = spliced; // RQ7
		end
		`OP_MLD_IND, `OP_MLD_XS, `OP_MLD_XL, `OP_MLD_DEC: begin
			wr_addr = (wsel == 2'h0) ? wreg(bb1[7:4]) :
				wreg({bb1[3:1], wsel == 2'h2 ? 1'b0 : 1'b1});
			wr_data = (wsel == 2'h0) ? md : (wsel == 2'h1) ?
				dec_sum[7:0] : dec_sum[15:8]; // RQ17 RQ20
		end
		default: begin
			if (op_ff[3:0] == `NIB_LD_IMM) begin
				wr_addr = wreg(op_ff[7:4]);
				wr_data = bb1;
			end else if (op_ff[3:0] == `NIB_LD_RSRC) begin
				wr_addr = wreg(op_ff[7:4]);
			end
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Strap synchroniser for the masked-ROM level
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rom_s1_ff <= 1'b0;
			rom_s2_ff <= 1'b0;
		end else begin
			rom_s1_ff <= rom_masked_in;
			rom_s2_ff <= rom_s1_ff;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Sequencer
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_ff     <= ST_OP;
			op_ff        <= 8'h00;
			b1_ff        <= 8'h00;
			b2_ff        <= 8'h00;
			b3_ff        <= 8'h00;
			bcnt_ff      <= 2'h0;
			cyc_ff       <= 4'h0;
			rd_idx_ff    <= 2'h0;
			wr_idx_ff    <= 2'h0;
			v0_ff        <= 8'h00;
			v1_ff        <= 8'h00;
			v2_ff        <= 8'h00;
			mdat_ff      <= 8'h00;
			jr_pend_ff   <= 1'b0;
			take_ff      <= 1'b1;
			pc_ff        <= `PC_RESET;
			pc_load_ff   <= 1'b0;
			cnd_ff       <= 4'h0;
			reg_addr_ff  <= 8'h00;
			reg_we_ff    <= 1'b0;
			reg_wdata_ff <= 8'h00;
			mem_addr_ff  <= 16'h0000;
			mem_space_ff <= 1'b0;
			mem_rd_ff    <= 1'b0;
			mem_wr_ff    <= 1'b0;
			mem_wdata_ff <= 8'h00;
			done_ff      <= 1'b0;
			illegal_ff   <= 1'b0;
		end else begin
			pc_load_ff <= 1'b0;
			done_ff    <= 1'b0;
			illegal_ff <= 1'b0;
			mem_rd_ff  <= 1'b0;
			mem_wr_ff  <= 1'b0;
			if (state_ff != ST_OP && cyc_ff != 4'hf)
				cyc_ff <= cyc_ff + 4'h1;
			if (taken)
				pc_ff <= pc_ff + 16'h0001; // RQ3
			case (state_ff)
			ST_OP: begin
				if (taken) begin
					op_ff   <= fetch_byte_in;
					cnd_ff  <= fetch_byte_in[7:4]; // RQ4
					cyc_ff  <= 4'h1;
					bcnt_ff <= 2'h0;
					if (d_nb == 3'h1) begin
						take_ff    <= 1'b0;
						illegal_ff <= 1'b1;
						state_ff   <= ST_PAD;
					end else begin
						state_ff <= ST_OPND;
					end
				end
			end
			ST_OPND: begin
				if (taken) begin
					bcnt_ff <= bcnt_ff + 2'h1;
					if (bcnt_ff == 2'h0)
						b1_ff <= fetch_byte_in;
					if (bcnt_ff == 2'h1)
						b2_ff <= fetch_byte_in;
					if (bcnt_ff == 2'h2)
						b3_ff <= fetch_byte_in;
					if (op_last) begin
						take_ff   <= 1'b0;
						rd_idx_ff <= 2'h0;
						wr_idx_ff <= 2'h0;
						if (d_jr) begin
							jr_pend_ff <= 1'b1;
							state_ff   <= ST_PAD;
						end else if (d_rdn != 2'h0) begin
							reg_addr_ff <= rd_addr;
							state_ff    <= ST_RD;
						end else begin
							reg_addr_ff  <= wr_addr;
							reg_wdata_ff <= wr_data;
							reg_we_ff    <= 1'b1;
							state_ff     <= ST_WR;
						end
					end
				end
			end
			ST_RD: begin
				if (rd_idx_ff == 2'h0)
					v0_ff <= reg_rdata_in;
				if (rd_idx_ff == 2'h1)
					v1_ff <= reg_rdata_in;
				if (rd_idx_ff == 2'h2)
					v2_ff <= reg_rdata_in;
				if (rd_idx_ff + 2'h1 != d_rdn) begin
					rd_idx_ff   <= rd_idx_ff + 2'h1;
					reg_addr_ff <= rd_addr;
				end else if (d_mem) begin
					mem_addr_ff  <= is_direct ? {b3_ff, b2_ff} :
						add_sum; // RQ15
					mem_space_ff <= b1_ff[0]; // RQ11 RQ15
					mem_rd_ff    <= d_ld; // RQ10
					mem_wr_ff    <= ~d_ld & ~store_blocked; // RQ16
					illegal_ff   <= ~d_ld & store_blocked;
					mem_wdata_ff <= vv2;
					state_ff     <= ST_MEM;
				end else begin
					reg_addr_ff  <= wr_addr;
					reg_wdata_ff <= wr_data;
					reg_we_ff    <= 1'b1;
					state_ff     <= ST_WR;
				end
			end
			ST_MEM: state_ff <= ST_MDAT;
			ST_MDAT: begin
				mdat_ff <= mem_rdata_in;
				if (d_wrn != 2'h0) begin
					reg_addr_ff  <= wr_addr;
					reg_wdata_ff <= wr_data;
					reg_we_ff    <= 1'b1;
					state_ff     <= ST_WR;
				end else begin
					state_ff <= ST_PAD;
				end
			end
			ST_WR: begin
				if (wr_idx_ff + 2'h1 != d_wrn) begin
					wr_idx_ff    <= wr_idx_ff + 2'h1;
					reg_addr_ff  <= wr_addr;
					reg_wdata_ff <= wr_data;
				end else begin
					reg_we_ff <= 1'b0;
					if (cyc_ff >= d_cyc - 4'h1) begin // RQ17
						take_ff  <= 1'b1;
						done_ff  <= 1'b1;
						state_ff <= ST_OP;
					end else begin
						state_ff <= ST_PAD;
					end
				end
			end
			ST_PAD: begin
				if (jr_pend_ff) begin
					jr_pend_ff <= 1'b0;
					if (cond_true_in) begin
						pc_ff      <= add_sum; // RQ1 RQ19
						pc_load_ff <= 1'b1;
					end
				end else if (cyc_ff >= d_cyc - 4'h1) begin
					take_ff  <= 1'b1;
					done_ff  <= 1'b1;
					state_ff <= ST_OP;
				end
			end
			default: state_ff <= ST_OP;
			endcase
		end
	end

	assign fetch_take_out     = take_ff;
	assign pc_out             = pc_ff;
	assign pc_load_out        = pc_load_ff;
	assign cond_code_out      = cnd_ff;
	assign reg_addr_out       = reg_addr_ff;
	assign reg_we_out         = reg_we_ff;
	assign reg_wdata_out      = reg_wdata_ff;
	assign mem_addr_out       = mem_addr_ff;
	assign mem_data_space_out = mem_space_ff;
	assign mem_rd_out         = mem_rd_ff;
	assign mem_wr_out         = mem_wr_ff;
	assign mem_wdata_out      = mem_wdata_ff;
	assign done_out           = done_ff;
	assign illegal_out        = illegal_ff;
endmodule

// ===== bench/exec_mem_model.sv
// Register file, program memory and external data memory beside the unit.
// Assumes reads answer one cycle after the strobe, as the unit expects.
`timescale 1ns/1ns
module exec_mem_model (
	input  wire        clk_in,
	input  wire [7:0]  reg_addr_in,
	output wire [7:0]  reg_rdata_out,
	input  wire        reg_we_in,
	input  wire [7:0]  reg_wdata_in,
	input  wire [15:0] mem_addr_in,
	input  wire        mem_space_in,
	input  wire        mem_rd_in,
	input  wire        mem_wr_in,
	input  wire [7:0]  mem_wdata_in,
	output logic [7:0] mem_rdata_out
);
	logic [7:0] rf [0:255];
	logic [7:0] pmem [0:65535];
	logic [7:0] dmem [0:65535];

	initial mem_rdata_out = 8'h00;
	assign reg_rdata_out = rf[reg_addr_in];

	////////////////////////////////////////////////////////////////////////
	// Outside a read slot the data lines toggle so stale data never passes
	always @(posedge clk_in) begin
		if (reg_we_in)
			rf[reg_addr_in] <= reg_wdata_in;
		if (mem_wr_in && mem_space_in)
			dmem[mem_addr_in] <= mem_wdata_in;
		if (mem_wr_in && !mem_space_in)
			pmem[mem_addr_in] <= mem_wdata_in;
		if (mem_rd_in)
			mem_rdata_out <= mem_space_in ? dmem[mem_addr_in]
				: pmem[mem_addr_in];
		else
			mem_rdata_out <= ~mem_rdata_out;
	end
endmodule

// ===== bench/branch_and_load_exec_unit_properties.sv
// Port-level checks of the branch and load unit.
// Assumes one clock domain; bound to the unit by the statement at the foot.
`timescale 1ns/1ns
module branch_and_load_exec_unit_checker (
	input wire        clk_in,
	input wire        rstn_in,
	input wire [7:0]  fetch_byte_in,
	input wire        fetch_valid_in,
	input wire        fetch_take_out,
	input wire [15:0] pc_out,
	input wire        pc_load_out,
	input wire        reg_we_out,
	input wire [7:0]  reg_wdata_out,
	input wire        mem_data_space_out,
	input wire        mem_rd_out,
	input wire        mem_wr_out,
	input wire [7:0]  mem_rdata_in,
	input wire        rom_masked_in,
	input wire        done_out
);
	logic [7:0] byte_d1_ff;
	logic [7:0] byte_d2_ff;

	// Delayed fetch bytes give the displacement at the redirect cycle
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			byte_d1_ff <= 8'h00;
			byte_d2_ff <= 8'h00;
		end else begin
			byte_d1_ff <= fetch_byte_in;
			byte_d2_ff <= byte_d1_ff;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	////////////////////////////////////////////////////////////////////////
	chk_branch_target: assert property (pc_load_out |->
		pc_out == $past(pc_out) + {{8{byte_d2_ff[7]}}, byte_d2_ff})
		else $error("branch target mismatch");
	chk_branch_done: assert property (pc_load_out |=>
		!pc_load_out ##2 done_out)
		else $error("branch did not end in six cycles");
	chk_pc_step: assert property (fetch_take_out && fetch_valid_in
		|=> pc_out == $past(pc_out) + 16'h0001)
		else $error("pc not stepped on byte take");
	chk_read_write: assert property (mem_rd_out |-> ##2
		(reg_we_out && reg_wdata_out == $past(mem_rdata_in)))
		else $error("read data not written to register");
	chk_read_pulse: assert property (mem_rd_out |=> !mem_rd_out)
		else $error("read strobe too long");
	chk_write_pulse: assert property (mem_wr_out |=> !mem_wr_out)
		else $error("write strobe too long");
	chk_we_span: assert property (reg_we_out[*3] |=> !reg_we_out)
		else $error("register write too long");
	chk_done_take: assert property (done_out |->
		fetch_take_out ##1 !done_out)
		else $error("done without take");
	chk_rom_store: assert property (rom_masked_in &&
		$past(rom_masked_in) && $past(rom_masked_in, 2) &&
		$past(rom_masked_in, 3) |-> !(mem_wr_out && !mem_data_space_out))
		else $error("program store on masked rom");
endmodule

bind branch_and_load_exec_unit branch_and_load_exec_unit_checker u_chk (
	.clk_in, .rstn_in, .fetch_byte_in, .fetch_valid_in, .fetch_take_out,
	.pc_out, .pc_load_out, .reg_we_out, .reg_wdata_out, .mem_data_space_out,
	.mem_rd_out, .mem_wr_out, .mem_rdata_in, .rom_masked_in, .done_out);

// ===== bench/branch_and_load_exec_unit_tb.sv
// Self-checking bench: feeds instructions, checks registers, memory, pc.
// Assumes the memory model stands behind the unit's register and memory ports.
`timescale 1ns/1ns
module branch_and_load_exec_unit_tb;
	logic        clk_in = 1'b0;
	logic        rstn_in = 1'b0;
	logic [7:0]  fetch_byte_in = 8'h00;
	logic        fetch_valid_in = 1'b0;
	logic        cond_true_in = 1'b0;
	logic [7:0]  wreg_base_in = 8'hc0;
	logic        rom_masked_in = 1'b0;
	wire         fetch_take_out, pc_load_out, reg_we_out, mem_data_space_out;
	wire         mem_rd_out, mem_wr_out, done_out, illegal_out;
	wire [15:0]  pc_out, mem_addr_out;
	wire [3:0]   cond_code_out;
	wire [7:0]   reg_addr_out, reg_rdata_in, reg_wdata_out;
	wire [7:0]   mem_wdata_out, mem_rdata_in;
	int          miscompares = 0;
	int          cmp_count = 0;
	logic [15:0] pc_exp = 16'h0000;
	logic        ill_seen = 1'b0;

	always #2 clk_in = ~clk_in;

	branch_and_load_exec_unit dut (.clk_in(clk_in), .rstn_in(rstn_in),
		.fetch_byte_in(fetch_byte_in), .fetch_valid_in(fetch_valid_in),
		.fetch_take_out(fetch_take_out), .pc_out(pc_out),
		.pc_load_out(pc_load_out), .cond_code_out(cond_code_out),
		.cond_true_in(cond_true_in), .wreg_base_in(wreg_base_in),
		.reg_addr_out(reg_addr_out), .reg_rdata_in(reg_rdata_in),
		.reg_we_out(reg_we_out), .reg_wdata_out(reg_wdata_out),
		.mem_addr_out(mem_addr_out), .mem_data_space_out(mem_data_space_out),
		.mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
		.mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in),
		.rom_masked_in(rom_masked_in), .done_out(done_out),
		.illegal_out(illegal_out));
	exec_mem_model u_mem (.clk_in(clk_in), .reg_addr_in(reg_addr_out),
		.reg_rdata_out(reg_rdata_in), .reg_we_in(reg_we_out),
		.reg_wdata_in(reg_wdata_out), .mem_addr_in(mem_addr_out),
		.mem_space_in(mem_data_space_out), .mem_rd_in(mem_rd_out),
		.mem_wr_in(mem_wr_out), .mem_wdata_in(mem_wdata_out),
		.mem_rdata_out(mem_rdata_in));

	////////////////////////////////////////////////////////////////////////
	task final_report;
		if (miscompares == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task cmp_w(input string what, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s exp %h got %h", what, e, g);
		end
	endtask

	task cmp_b(input string what, input logic [7:0] e, input logic [7:0] g);
		cmp_w(what, {8'h00, e}, {8'h00, g});
	endtask

	task cmp_n(input string what, input int e, input int g);
		cmp_count++;
		if (g != e) begin
			miscompares++;
			$display("wrong value %s exp %0d got %0d", what, e, g);
		end
	endtask

	// Feeds one instruction, waits for done, checks cycle count and pc
	task automatic run(input logic [7:0] b0, b1, b2, b3, input int len,
		input int cyc, input logic [15:0] adj);
		logic [7:0] bs [4];
		int i;
		int n;
		bs = '{b0, b1, b2, b3};
		n = 0;
		ill_seen = 1'b0;
		for (i = 0; i < len; i++) begin
			@(negedge clk_in);
			n++;
			fetch_valid_in = 1'b1;
			fetch_byte_in = bs[i];
			while (fetch_take_out !== 1'b1 && n < 40) begin
				@(negedge clk_in);
				n++;
			end
			@(posedge clk_in);
			if (i == 0)
				n = 0;
		end
		@(negedge clk_in);
		n++;
		fetch_valid_in = 1'b0;
		while (done_out !== 1'b1 && n < 40) begin
			if (illegal_out === 1'b1)
				ill_seen = 1'b1;
			@(negedge clk_in);
			n++;
		end
		if (illegal_out === 1'b1)
			ill_seen = 1'b1;
		pc_exp = pc_exp + len[15:0] + adj;
		cmp_n("cycles", cyc, n);
		cmp_w("pc", pc_exp, pc_out);
	endtask

	////////////////////////////////////////////////////////////////////////
	task t_branch;
		cond_true_in = 1'b1;
		run(8'h7b, 8'h80, 8'h00, 8'h00, 2, 6, 16'hff80);
		cmp_b("cond", 8'h07, {4'h0, cond_code_out});
		run(8'h3b, 8'h7f, 8'h00, 8'h00, 2, 6, 16'h007f);
		cond_true_in = 1'b0;
		run(8'hfb, 8'h10, 8'h00, 8'h00, 2, 6, 16'h0000);
	endtask

	task t_load;
		u_mem.rf[8'h3a] = 8'h5a;
		run(8'h3c, 8'h10, 8'h00, 8'h00, 2, 4, 16'h0000);
		cmp_b("imm", 8'h10, u_mem.rf[8'hc3]);
		run(8'h58, 8'h3a, 8'h00, 8'h00, 2, 4, 16'h0000);
		cmp_b("rsrc", 8'h5a, u_mem.rf[8'hc5]);
		cmp_b("src kept", 8'h5a, u_mem.rf[8'h3a]);
		run(8'h39, 8'h40, 8'h00, 8'h00, 2, 4, 16'h0000);
		cmp_b("rdst", 8'h10, u_mem.rf[8'h40]);
		run(8'he4, 8'h3a, 8'h41, 8'h00, 3, 6, 16'h0000);
		cmp_b("reg reg", 8'h5a, u_mem.rf[8'h41]);
		run(8'he6, 8'h42, 8'h99, 8'h00, 3, 6, 16'h0000);
		cmp_b("reg imm", 8'h99, u_mem.rf[8'h42]);
	endtask

	task t_bitload;
		u_mem.rf[8'hc0] = 8'h06;
		u_mem.rf[8'h00] = 8'h05;
		run(8'h47, 8'h04, 8'h00, 8'h00, 3, 6, 16'h0000);
		cmp_b("bit in", 8'h07, u_mem.rf[8'hc0]);
		cmp_b("bit src", 8'h05, u_mem.rf[8'h00]);
		u_mem.rf[8'hc0] = 8'h06;
		run(8'h47, 8'h01, 8'h00, 8'h00, 3, 6, 16'h0000);
		cmp_b("bit out", 8'h04, u_mem.rf[8'h00]);
		u_mem.rf[8'hc1] = 8'h01;
		u_mem.rf[8'h10] = 8'h00;
		run(8'h47, 8'h1f, 8'h10, 8'h00, 3, 6, 16'h0000);
		cmp_b("bit seven", 8'h80, u_mem.rf[8'h10]);
	endtask

	task t_memload;
		u_mem.rf[8'hc2] = 8'h01;
		u_mem.rf[8'hc3] = 8'h04;
		u_mem.pmem[16'h0104] = 8'h1a;
		u_mem.dmem[16'h0104] = 8'h2a;
		u_mem.pmem[16'h0105] = 8'h6d;
		u_mem.pmem[16'h1104] = 8'h88;
		u_mem.dmem[16'h1104] = 8'h98;
		run(8'hc3, 8'h02, 8'h00, 8'h00, 2, 10, 16'h0000);
		cmp_b("ind prog", 8'h1a, u_mem.rf[8'hc0]);
		run(8'hc3, 8'h03, 8'h00, 8'h00, 2, 10, 16'h0000);
		cmp_b("ind data", 8'h2a, u_mem.rf[8'hc0]);
		u_mem.rf[8'hc0] = 8'h11;
		run(8'hd3, 8'h03, 8'h00, 8'h00, 2, 10, 16'h0000);
		cmp_b("ind store", 8'h11, u_mem.dmem[16'h0104]);
		run(8'he7, 8'h02, 8'h01, 8'h00, 3, 12, 16'h0000);
		cmp_b("short idx", 8'h6d, u_mem.rf[8'hc0]);
		run(8'ha7, 8'h02, 8'h00, 8'h10, 4, 14, 16'h0000);
		cmp_b("long idx", 8'h88, u_mem.rf[8'hc0]);
		run(8'ha7, 8'h01, 8'h04, 8'h11, 4, 14, 16'h0000);
		cmp_b("direct data", 8'h98, u_mem.rf[8'hc0]);
		run(8'ha7, 8'h00, 8'h04, 8'h11, 4, 14, 16'h0000);
		cmp_b("direct prog", 8'h88, u_mem.rf[8'hc0]);
		run(8'hb7, 8'h01, 8'h05, 8'h11, 4, 14, 16'h0000);
		cmp_b("direct store", 8'h88, u_mem.dmem[16'h1105]);
		cmp_b("pair kept", 8'h04, u_mem.rf[8'hc3]);
	endtask

	task t_postdec;
		u_mem.rf[8'hc6] = 8'h10;
		u_mem.rf[8'hc7] = 8'h00;
		u_mem.pmem[16'h1000] = 8'hcd;
		u_mem.dmem[16'h0fff] = 8'h77;
		run(8'he2, 8'h86, 8'h00, 8'h00, 2, 10, 16'h0000);
		cmp_b("dec dst", 8'hcd, u_mem.rf[8'hc8]);
		cmp_w("dec pair", 16'h0fff, {u_mem.rf[8'hc6], u_mem.rf[8'hc7]});
		run(8'he2, 8'h87, 8'h00, 8'h00, 2, 10, 16'h0000);
		cmp_b("dec data", 8'h77, u_mem.rf[8'hc8]);
		cmp_w("dec again", 16'h0ffe, {u_mem.rf[8'hc6], u_mem.rf[8'hc7]});
	endtask

	task t_masked;
		rom_masked_in = 1'b1;
		repeat (4) @(negedge clk_in);
		u_mem.pmem[16'h0104] = 8'h00;
		run(8'hd3, 8'h02, 8'h00, 8'h00, 2, 10, 16'h0000);
		cmp_b("rom refused", 8'h01, {7'h00, ill_seen});
		cmp_b("rom kept", 8'h00, u_mem.pmem[16'h0104]);
		run(8'hff, 8'h00, 8'h00, 8'h00, 1, 4, 16'h0000);
		cmp_b("unknown op", 8'h01, {7'h00, ill_seen});
		rom_masked_in = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		#20000;
		miscompares++;
		final_report;
	end

	initial begin
		repeat (8) @(posedge clk_in);
		@(negedge clk_in);
		rstn_in = 1'b1;
		t_branch;
		t_load;
		t_bitload;
		t_memload;
		t_postdec;
		t_masked;
		final_report;
	end
endmodule
